// ---- hdl/bank_addr_core.sv ----
// Bank extension registers, 20-bit address former, transfer splitter and MAC registers.
// Assumes requests come from the instruction sequencer, one at a time, while idle.
//
// How it works
// - six 4-bit bank fields, three homes
// - index, program and stack banks extend registers
// - extended bank gives upper four address bits
// - address is bank over 16-bit byte address
// - every address source is 20 bits wide
// - sixteen 64K banks, bank chosen by field
// - fetches and reset vectors use program space
// - MAC holds two fractions, accumulator, two masks
// - MAC keeps a running sum of products
// - 16-bit fraction sign at bit 15
// - 32-bit fraction sign at bit 31
// - 36-bit accumulator, sign 35, extension 34:31
// - two signed nibbles per byte as MAC offsets
// - long operands only for multiply, divide, pairs
// - decimal operands move as bytes
// - bit test byte only, set/clear byte or word
// - word is two bytes, low byte first
// - long word is two words from byte 0
// - fetches always go to word addresses
// - odd word access splits into two bytes
// - address bit 0 low on every fetch
// - bank carry changes address, not stored fields
`timescale 1ns/1ps
module bank_addr_core (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire logic [bank_fmt_pkg::REG_AW-1:0] reg_addr,
    input wire logic [bank_fmt_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [bank_fmt_pkg::DATA_W-1:0] reg_rdata,
    // Access request
    input wire logic acc_req,
    input wire bank_fmt_pkg::src_t acc_src,
    input wire bank_fmt_pkg::kind_t acc_kind,
    input wire bank_fmt_pkg::size_t acc_size,
    input wire bank_fmt_pkg::bitop_t acc_bitop,
    input wire logic [15:0] acc_offset,
    input wire logic acc_reset_vec,
    input wire logic acc_bcd,
    input wire logic acc_long_ok,
    output logic acc_busy,
    output logic acc_done,
    output logic acc_error,
    // Memory bus
    output logic bus_strobe,
    output logic [bank_fmt_pkg::ADDR_W-1:0] bus_addr,
    output logic bus_word,
    output logic bus_program
);
    import bank_fmt_pkg::*;

    typedef struct packed {
        logic [15:0] ext_k;
        logic [15:0] ccr;
        logic [3:0] stack_bank;
        logic [15:0] ix;
        logic [15:0] iy;
        logic [15:0] iz;
        logic [15:0] pc;
        logic [15:0] sp;
        logic [15:0] mul_h;
        logic [15:0] mul_i;
        logic [7:0] xmask;
        logic [7:0] ymask;
        logic [7:0] mac_ofs;
        seq_t seq;
        logic [19:0] cur;
        logic [19:0] last_ea;
        logic [2:0] left;
        logic misal;
        logic busy;
        logic done;
        logic error;
        logic strobe;
        logic word;
        logic prog;
        logic [19:0] bus_addr;
        logic [15:0] rdata;
    } state_t;

    state_t st;
    state_t next_st;

    logic mac_start;
    logic mac_clear;
    logic mac_load;
    logic [MAC_W-1:0] mac_load_val;
    logic [MAC_W-1:0] mac_acc;
    logic mac_step;
    logic mac_busy;

    // Bank fields: four in the extension register, one in the CCR, one alone
    logic [3:0] ek;
    logic [3:0] xk;
    logic [3:0] yk;
    logic [3:0] zk;
    logic [3:0] pk;
    assign ek = st.ext_k[EK_LSB+:BANK_W];
    assign xk = st.ext_k[XK_LSB+:BANK_W];
    assign yk = st.ext_k[YK_LSB+:BANK_W];
    assign zk = st.ext_k[ZK_LSB+:BANK_W];
    assign pk = st.ccr[PK_LSB+:BANK_W];

    // MAC control decoded straight from register writes
    assign mac_start = reg_wr && reg_addr == R_MAC_CMD;
    assign mac_clear = mac_start && reg_wdata[MAC_CLR_BIT];
    assign mac_load = reg_wr && (reg_addr == R_AM_EXT || reg_addr == R_AM_HI
                      || reg_addr == R_AM_LO);

    // Accumulator pieces are written one at a time, the rest kept
    always_comb begin
        mac_load_val = mac_acc;
        unique case (reg_addr)
            R_AM_EXT: mac_load_val[35:32] = reg_wdata[3:0];
            R_AM_HI: mac_load_val[31:16] = reg_wdata;
            R_AM_LO: mac_load_val[15:0] = reg_wdata;
            default: mac_load_val = mac_acc;
        endcase
    end

    mac_unit u_mac (
        .clk_sys(clk_sys),
        .reset(reset),
        .start(mac_start),
        .clear(mac_clear),
        .load(mac_load),
        .load_val(mac_load_val),
        .reps(reg_wdata[REP_W-1:0]),
        .mult_h(st.mul_h),
        .mult_i(st.mul_i),
        .acc(mac_acc),
        .step(mac_step),
        .busy(mac_busy)
    );

    // Register file, index stepping, read port and transfer sequencer
    always_comb begin
        logic [3:0] bank;
        logic [15:0] base;
        logic [19:0] ea;
        logic [2:0] step;
        logic use_word;
        logic bad;
        size_t size;
        src_t src;
        bank = 4'h0;
        base = 16'h0000;
        ea = 20'h00000;
        step = 3'h1;
        use_word = 1'b0;
        bad = 1'b0;
        size = acc_size;
        src = acc_src;
        next_st = st;
        next_st.done = 1'b0;
        next_st.error = 1'b0;
        next_st.strobe = 1'b0;
        next_st.rdata = 16'h0000;

        // Software writes; unmapped offsets are ignored
        if (reg_wr) begin
            unique case (reg_addr)
                R_EXT_K: next_st.ext_k = reg_wdata;
                R_CCR: next_st.ccr = reg_wdata;
                R_STACK_BANK: next_st.stack_bank = reg_wdata[3:0];
                R_IX: next_st.ix = reg_wdata;
                R_IY: next_st.iy = reg_wdata;
                R_IZ: next_st.iz = reg_wdata;
                R_PC: next_st.pc = reg_wdata;
                R_SP: next_st.sp = reg_wdata;
                R_MUL_H: next_st.mul_h = reg_wdata;
                R_MUL_I: next_st.mul_i = reg_wdata;
                R_XMASK: next_st.xmask = reg_wdata[7:0];
                R_YMASK: next_st.ymask = reg_wdata[7:0];
                R_MAC_CMD: next_st.mac_ofs = reg_wdata[MAC_OFS_LSB+:8];
                default: next_st.rdata = 16'h0000;
            endcase
        end

        // Each MAC step walks X and Y by the packed nibble offsets
        if (mac_step) begin
            next_st.ix = mod_step(st.ix, st.mac_ofs[7:4], st.xmask);
            next_st.iy = mod_step(st.iy, st.mac_ofs[3:0], st.ymask);
        end

        // Reads answer one cycle later; unmapped offsets read zero
        if (reg_rd) begin
            unique case (reg_addr)
                R_EXT_K: next_st.rdata = st.ext_k;
                R_CCR: next_st.rdata = st.ccr;
                R_STACK_BANK: next_st.rdata = {12'h000, st.stack_bank};
                R_IX: next_st.rdata = st.ix;
                R_IY: next_st.rdata = st.iy;
                R_IZ: next_st.rdata = st.iz;
                R_PC: next_st.rdata = st.pc;
                R_SP: next_st.rdata = st.sp;
                R_MUL_H: next_st.rdata = st.mul_h;
                R_MUL_I: next_st.rdata = st.mul_i;
                R_AM_EXT: next_st.rdata = {12'h000, mac_acc[35:32]};
                R_AM_HI: next_st.rdata = mac_acc[31:16];
                R_AM_LO: next_st.rdata = mac_acc[15:0];
                R_XMASK: next_st.rdata = {8'h00, st.xmask};
                R_YMASK: next_st.rdata = {8'h00, st.ymask};
                R_MAC_CMD: next_st.rdata = {st.mac_ofs, 7'h00, mac_busy};
                R_EA_HI: next_st.rdata = {12'h000, st.last_ea[19:16]};
                R_EA_LO: next_st.rdata = st.last_ea[15:0];
                R_STATUS: next_st.rdata = {13'h0000, st.error, mac_busy, st.busy};
                default: next_st.rdata = 16'h0000;
            endcase
        end

        unique case (st.seq)
            SEQ_IDLE: begin
                if (acc_req) begin
                    // Fetches and stack traffic pick their own base register
                    if (acc_kind == KIND_FETCH) begin
                        src = SRC_PC;
                        size = SIZE_WORD;
                    end else if (acc_kind == KIND_STACK) begin
                        src = SRC_SP;
                    end
                    if (acc_bcd) begin
                        size = SIZE_BYTE;
                    end
                    // Operand sizes that the operation cannot take are refused
                    bad = (acc_bitop == BIT_TEST && size != SIZE_BYTE)
                          || (acc_bitop != BIT_NONE && size == SIZE_LONG)
                          || (size == SIZE_LONG && !acc_long_ok);
                    unique case (src)
                        SRC_EXT: bank = ek;
                        SRC_X: bank = xk;
                        SRC_Y: bank = yk;
                        SRC_Z: bank = zk;
                        SRC_PC: bank = pk;
                        SRC_SP: bank = st.stack_bank;
                        default: bank = 4'h0;
                    endcase
                    unique case (src)
                        SRC_X: base = st.ix;
                        SRC_Y: base = st.iy;
                        SRC_Z: base = st.iz;
                        SRC_PC: base = st.pc;
                        SRC_SP: base = st.sp;
                        default: base = 16'h0000;
                    endcase
                    // Extended mode takes the offset as the byte address itself
                    if (src == SRC_EXT) begin
                        ea = {bank, acc_offset};
                    end else begin
                        ea = ea_add(bank, base, acc_offset);
                    end
                    if (acc_kind == KIND_FETCH) begin
                        ea[0] = 1'b0;
                    end
                    // Space marked at every take, so a refusal leaves no stale mark
                    next_st.prog = acc_kind == KIND_FETCH
                                   || (acc_kind == KIND_VECTOR && acc_reset_vec);
                    if (bad) begin
                        next_st.error = 1'b1;
                        next_st.done = 1'b1;
                    end else begin
                        next_st.busy = 1'b1;
                        next_st.seq = SEQ_XFER;
                        next_st.cur = ea;
                        next_st.last_ea = ea;
                        next_st.left = size_bytes(size);
                        next_st.misal = ea[0];
                    end
                end
            end
            SEQ_XFER: begin
                // Word moves only at even addresses; odd ones go byte by byte
                use_word = !st.misal && st.left >= 3'h2;
                step = use_word ? 3'h2 : 3'h1;
                next_st.strobe = 1'b1;
                next_st.word = use_word;
                next_st.bus_addr = st.cur;
                // Carry across 64K runs into the bank bits only on the bus side
                next_st.cur = st.cur + {17'h00000, step};
                next_st.left = st.left - step;
                if (st.left == step) begin
                    next_st.seq = SEQ_IDLE;
                    next_st.busy = 1'b0;
                    next_st.done = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign acc_busy = st.busy;
    assign acc_done = st.done;
    assign acc_error = st.error;
    assign bus_strobe = st.strobe;
    assign bus_addr = st.bus_addr;
    assign bus_word = st.word;
    assign bus_program = st.prog;

    // Request taken while idle, of a given kind
    sequence s_take(kind_t k);
        acc_req && !acc_busy && acc_kind == k;
    endsequence

    // A long operand from an even extended address
    sequence s_long_even;
        s_take(KIND_DATA) ##0 (acc_size == SIZE_LONG && acc_long_ok && acc_src == SRC_EXT
            && !acc_offset[0] && acc_bitop == BIT_NONE && !acc_bcd);
    endsequence

    a_fetch_program: assert property (@(posedge clk_sys) disable iff (reset)
        s_take(KIND_FETCH) |=> ##1 (bus_strobe && bus_word && bus_program && !bus_addr[0]))
        else $error("fetch not word aligned in program space");

    a_data_space: assert property (@(posedge clk_sys) disable iff (reset)
        s_take(KIND_DATA) |=> ##1 !bus_program)
        else $error("data access marked as program space");

    a_odd_bytes: assert property (@(posedge clk_sys) disable iff (reset)
        bus_strobe && bus_addr[0] |-> !bus_word)
        else $error("word transfer at odd address");

    a_addr_step: assert property (@(posedge clk_sys) disable iff (reset)
        bus_strobe && $past(bus_strobe)
            |-> bus_addr == $past(bus_addr) + ($past(bus_word) ? 20'h00002 : 20'h00001))
        else $error("address did not advance across transfer");

    a_ext_form: assert property (@(posedge clk_sys) disable iff (reset)
        s_take(KIND_DATA) ##0 (acc_src == SRC_EXT && acc_size != SIZE_LONG
            && acc_bitop == BIT_NONE)
            |=> ##1 (bus_strobe && bus_addr == {$past(ek, 2), $past(acc_offset, 2)}))
        else $error("extended address not bank over offset");

    a_long_pair: assert property (@(posedge clk_sys) disable iff (reset)
        s_long_even |=> ##1 (bus_strobe && bus_word) ##1 (bus_strobe && bus_word)
            ##1 !bus_strobe)
        else $error("long word not two word transfers");

    a_test_refused: assert property (@(posedge clk_sys) disable iff (reset)
        acc_req && !acc_busy && acc_bitop == BIT_TEST && acc_size != SIZE_BYTE && !acc_bcd
            && acc_kind != KIND_FETCH |=> acc_error && acc_done && !acc_busy)
        else $error("word bit test not refused");

    a_long_refused: assert property (@(posedge clk_sys) disable iff (reset)
        acc_req && !acc_busy && acc_size == SIZE_LONG && !acc_long_ok && !acc_bcd
            && acc_kind != KIND_FETCH |=> acc_error ##1 !bus_strobe)
        else $error("long operand accepted without permission");

    a_bank_held: assert property (@(posedge clk_sys) disable iff (reset)
        !(reg_wr && reg_addr == R_EXT_K) |=> $stable(st.ext_k))
        else $error("bank fields changed without a write");

endmodule : bank_addr_core

// ---- hdl/bank_fmt_pkg.sv ----
// Shared constants, types and helpers for the bank address and data format core.
// Assumes a single 10 MHz system clock and a synchronous active-high reset.
package bank_fmt_pkg;

    // Address space shape
    localparam int BANK_W = 4;
    localparam int BYTE_ADDR_W = 16;
    localparam int ADDR_W = 20;
    localparam int BANK_COUNT = 16;
    localparam int BANK_BYTES = 65536;
    localparam int DATA_W = 16;
    localparam int REG_AW = 5;
    localparam int MAC_W = 36;
    localparam int MASK_W = 8;
    localparam int REP_W = 6;

    // Register offsets
    localparam logic [4:0] R_EXT_K = 5'h00;
    localparam logic [4:0] R_CCR = 5'h01;
    localparam logic [4:0] R_STACK_BANK = 5'h02;
    localparam logic [4:0] R_IX = 5'h03;
    localparam logic [4:0] R_IY = 5'h04;
    localparam logic [4:0] R_IZ = 5'h05;
    localparam logic [4:0] R_PC = 5'h06;
    localparam logic [4:0] R_SP = 5'h07;
    localparam logic [4:0] R_MUL_H = 5'h08;
    localparam logic [4:0] R_MUL_I = 5'h09;
    localparam logic [4:0] R_AM_EXT = 5'h0a;
    localparam logic [4:0] R_AM_HI = 5'h0b;
    localparam logic [4:0] R_AM_LO = 5'h0c;
    localparam logic [4:0] R_XMASK = 5'h0d;
    localparam logic [4:0] R_YMASK = 5'h0e;
    localparam logic [4:0] R_MAC_CMD = 5'h0f;
    localparam logic [4:0] R_EA_HI = 5'h10;
    localparam logic [4:0] R_EA_LO = 5'h11;
    localparam logic [4:0] R_STATUS = 5'h12;

    // Field positions in the extension register, condition codes and MAC command
    localparam int EK_LSB = 12;
    localparam int XK_LSB = 8;
    localparam int YK_LSB = 4;
    localparam int ZK_LSB = 0;
    localparam int PK_LSB = 0;
    localparam int MAC_OFS_LSB = 8;
    localparam int MAC_CLR_BIT = 6;

    // Fraction and accumulator format
    localparam logic [15:0] FRAC16_MIN = 16'h8000;
    localparam logic [15:0] FRAC16_MAX = 16'h7fff;
    localparam logic [31:0] FRAC32_MIN = 32'h80000000;
    localparam int ACC_SIGN = 35;
    localparam int ACC_EXT_MSB = 34;
    localparam int ACC_EXT_LSB = 31;

    typedef enum logic [2:0] {SRC_EXT, SRC_X, SRC_Y, SRC_Z, SRC_PC, SRC_SP} src_t;
    typedef enum logic [1:0] {KIND_FETCH, KIND_DATA, KIND_STACK, KIND_VECTOR} kind_t;
    typedef enum logic [1:0] {SIZE_BYTE, SIZE_WORD, SIZE_LONG} size_t;
    typedef enum logic [1:0] {BIT_NONE, BIT_SET, BIT_CLEAR, BIT_TEST} bitop_t;
    typedef enum logic [1:0] {SEQ_IDLE = 2'b00, SEQ_XFER = 2'b01} seq_t;

    // Bank:byte plus signed offset; the carry runs into the bank bits
    function automatic logic [19:0] ea_add(input logic [3:0] bank, input logic [15:0] base,
                                           input logic [15:0] ofs);
        return {bank, base} + {{4{ofs[15]}}, ofs};
    endfunction : ea_add

    // Bytes moved by one access of the given size
    function automatic logic [2:0] size_bytes(input size_t size);
        return (size == SIZE_LONG) ? 3'h4 : (size == SIZE_WORD) ? 3'h2 : 3'h1;
    endfunction : size_bytes

    // Fractional product aligned to the accumulator radix point
    function automatic logic [35:0] frac_mul(input logic [15:0] a, input logic [15:0] b);
        logic signed [31:0] p;
        p = $signed(a) * $signed(b);
        // Shift puts the radix between bits 31 and 30, sign copied up
        return {{3{p[31]}}, p, 1'b0};
    endfunction : frac_mul

    // Index step by a signed nibble, kept inside the modulo window when the mask is nonzero
    function automatic logic [15:0] mod_step(input logic [15:0] r, input logic [3:0] ofs,
                                             input logic [7:0] mask);
        logic [15:0] sum;
        sum = r + {{12{ofs[3]}}, ofs};
        if (mask == 8'h00) begin
            return sum;
        end
        return (r & ~{8'h00, mask}) | (sum & {8'h00, mask});
    endfunction : mod_step

endpackage : bank_fmt_pkg

// ---- hdl/mac_unit.sv ----
// Repeating fractional multiply-accumulate engine with a 36-bit running total.
// Assumes multiplier and multiplicand are held steady while a run is active.
`timescale 1ns/1ps
module mac_unit (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Control
    input wire logic start,
    input wire logic clear,
    input wire logic load,
    input wire logic [bank_fmt_pkg::MAC_W-1:0] load_val,
    input wire logic [bank_fmt_pkg::REP_W-1:0] reps,
    // Operands
    input wire logic [15:0] mult_h,
    input wire logic [15:0] mult_i,
    // Results
    output logic [bank_fmt_pkg::MAC_W-1:0] acc,
    output logic step,
    output logic busy
);
    import bank_fmt_pkg::*;

    typedef struct packed {
        logic [MAC_W-1:0] acc;
        logic [REP_W-1:0] left;
        logic busy;
        logic step;
    } mac_state_t;

    mac_state_t st;
    mac_state_t next_st;

    // One product per cycle; reps plus one steps per run
    always_comb begin
        next_st = st;
        next_st.step = 1'b0;
        if (clear) begin
            next_st.acc = '0;
        end else if (load) begin
            next_st.acc = load_val;
        end
        if (st.busy) begin
            next_st.acc = st.acc + frac_mul(mult_h, mult_i);
            next_st.step = 1'b1;
            if (st.left == 6'h00) begin
                next_st.busy = 1'b0;
            end else begin
                next_st.left = st.left - 6'h01;
            end
        end else if (start) begin
            next_st.busy = 1'b1;
            next_st.left = reps;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign acc = st.acc;
    assign step = st.step;
    assign busy = st.busy;

    a_mac_accumulate: assert property (@(posedge clk_sys) disable iff (reset)
        busy |=> acc == $past(acc) + frac_mul($past(mult_h), $past(mult_i)))
        else $error("accumulator missed a product");

    a_mac_single_run: assert property (@(posedge clk_sys) disable iff (reset)
        start && !busy && reps == 6'h00 |=> busy ##1 (step && !busy))
        else $error("single-step run has wrong length");

endmodule : mac_unit

// ---- bench/bus_mem_model.sv ----
// Far-side memory model: logs every transfer that the core puts on the internal bus.
// Assumes one clock shared with the core and strobes one cycle long.
`timescale 1ns/1ps
module bus_mem_model (
    // Clock
    input wire logic clk_sys,
    // Bus from the core
    input wire logic bus_strobe,
    input wire logic [19:0] bus_addr,
    input wire logic bus_word,
    input wire logic bus_program,
    // Observed transfer, one cycle late
    output logic seen,
    output logic [21:0] seen_xfer
);
    // Capture only on strobe; address lines hold the last transfer's address between strobes
    always_ff @(posedge clk_sys) begin
        seen <= bus_strobe;
        if (bus_strobe) begin
            seen_xfer <= {bus_addr, bus_word, bus_program};
        end
    end
endmodule : bus_mem_model

// ---- bench/tb.sv ----
// Self-checking bench for the bank address core: register port, transfers, MAC.
// Assumes the memory model sits on the bus and reports each transfer one cycle late.
`timescale 1ns/1ps
`define CHK(a, e) begin logic [63:0] exp_v; exp_v = 64'(e); comparisons++; \
    if ((a) !== exp_v) begin fail_count++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, a, exp_v); end end
module tb;
    import bank_fmt_pkg::*;
    logic clk_sys = 0, reset = 1, reg_wr = 0, reg_rd = 0, acc_req = 0, acc_reset_vec = 0;
    logic acc_bcd = 0, acc_long_ok = 0, acc_busy, acc_done, acc_error, bus_strobe;
    logic bus_word, bus_program, seen, rd_q = 0;
    logic [4:0] reg_addr = 0;
    logic [15:0] reg_wdata = 0, reg_rdata, acc_offset = 0;
    logic [19:0] bus_addr;
    logic [21:0] seen_xfer;
    logic [3:0] ek;
    src_t acc_src = SRC_EXT;
    kind_t acc_kind = KIND_DATA;
    size_t acc_size = SIZE_BYTE;
    bitop_t acc_bitop = BIT_NONE;
    int fail_count = 0, comparisons = 0;
    logic [15:0] rq[$];
    logic [21:0] bq[$];
    bank_addr_core dut_u (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .acc_req(acc_req), .acc_src(acc_src), .acc_kind(acc_kind), .acc_size(acc_size),
        .acc_bitop(acc_bitop), .acc_offset(acc_offset), .acc_reset_vec(acc_reset_vec),
        .acc_bcd(acc_bcd), .acc_long_ok(acc_long_ok), .acc_busy(acc_busy),
        .acc_done(acc_done), .acc_error(acc_error), .bus_strobe(bus_strobe),
        .bus_addr(bus_addr), .bus_word(bus_word), .bus_program(bus_program));
    bus_mem_model mem_u (.clk_sys(clk_sys), .bus_strobe(bus_strobe), .bus_addr(bus_addr),
        .bus_word(bus_word), .bus_program(bus_program), .seen(seen), .seen_xfer(seen_xfer));
    // 100 ns period
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    // Read data stands only in the cycle after the strobe
    always @(posedge clk_sys) rd_q <= reg_rd;
    // Watcher: oldest note against each result as it appears
    always @(negedge clk_sys) begin
        if (rd_q === 1'b1) `CHK(reg_rdata, rq.pop_front())
        if (seen === 1'b1) `CHK(seen_xfer, bq.pop_front())
    end
    task automatic wr(logic [4:0] a, logic [15:0] d);
        @(posedge clk_sys) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk_sys) reg_wr <= 0;
    endtask : wr
    task automatic rd(logic [4:0] a, logic [15:0] e);
        rq.push_back(e);
        @(posedge clk_sys) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk_sys) reg_rd <= 0;
    endtask : rd
    // One request, raised for one cycle, then wait for done; a refusal must leave the bus quiet
    task automatic acc(src_t s, kind_t k, size_t z, logic [15:0] o, logic err = 0,
                       bitop_t b = BIT_NONE, logic lok = 0, logic bcd = 0, logic rv = 0);
        int n;
        n = 0;
        @(posedge clk_sys) begin
            {acc_req, acc_offset, acc_long_ok, acc_bcd, acc_reset_vec} <= {1'b1, o, lok, bcd, rv};
            acc_src <= s;
            acc_kind <= k;
            acc_size <= z;
            acc_bitop <= b;
        end
        @(posedge clk_sys) acc_req <= 0;
        do begin
            @(negedge clk_sys);
            n++;
            if (n == 1) `CHK(acc_busy, !err)
        end while (acc_done !== 1'b1 && n < 20);
        `CHK(acc_done, 1'b1)
        `CHK(acc_error, err)
        repeat (2) @(posedge clk_sys);
    endtask : acc
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    // Watchdog: the sequence needs well under a millisecond
    initial begin
        #2ms;
        fail_count++;
        complete_run;
    end
    initial begin
        ek = 4'($urandom(32'h8f9e));
        ek = 4'($urandom());
        repeat (20) @(posedge clk_sys);
        reset <= 0;
        rd(R_EXT_K, 16'h0000); rd(R_SP, 16'h0000); rd(5'h1f, 16'h0000);
        wr(R_EXT_K, {ek, 12'h300}); wr(R_CCR, 16'h0009); wr(R_STACK_BANK, 16'h0002);
        wr(R_IX, 16'hffff); wr(R_PC, 16'h0101); wr(R_SP, 16'h1000);
        $display("registers done");
        bq.push_back({ek, 16'h1234, 2'b10});
        acc(SRC_EXT, KIND_DATA, SIZE_WORD, 16'h1234);
        bq.push_back({20'h40001, 2'b00}); bq.push_back({20'h40002, 2'b00});
        acc(SRC_X, KIND_DATA, SIZE_WORD, 16'h0002);
        rd(R_EXT_K, {ek, 12'h300});
        bq.push_back({20'h90100, 2'b11});
        acc(SRC_PC, KIND_FETCH, SIZE_BYTE, 16'h0000);
        bq.push_back({20'h00000, 2'b11}); bq.push_back({20'h00010, 2'b10});
        acc(SRC_Z, KIND_VECTOR, SIZE_WORD, 16'h0000, 0, BIT_NONE, 0, 0, 1);
        acc(SRC_Z, KIND_VECTOR, SIZE_WORD, 16'h0010);
        bq.push_back({20'h21000, 2'b10});
        acc(SRC_SP, KIND_STACK, SIZE_WORD, 16'h0000);
        $display("addressing done");
        bq.push_back({ek, 16'h0100, 2'b10}); bq.push_back({ek, 16'h0102, 2'b10});
        acc(SRC_EXT, KIND_DATA, SIZE_LONG, 16'h0100, 0, BIT_NONE, 1);
        acc(SRC_EXT, KIND_DATA, SIZE_LONG, 16'h0100, 1);
        acc(SRC_EXT, KIND_DATA, SIZE_WORD, 16'h0100, 1, BIT_TEST);
        acc(SRC_EXT, KIND_DATA, SIZE_LONG, 16'h0100, 1, BIT_SET, 1);
        bq.push_back({ek, 16'h0300, 2'b10}); bq.push_back({ek, 16'h0200, 2'b00});
        acc(SRC_EXT, KIND_DATA, SIZE_WORD, 16'h0300, 0, BIT_CLEAR);
        acc(SRC_EXT, KIND_DATA, SIZE_WORD, 16'h0200, 0, BIT_NONE, 0, 1);
        $display("formats done");
        // Half times half, two steps: radix sits between bits 31 and 30
        // Offsets X +1, Y -1 per step: X wraps past ffff, Y goes below zero
        wr(R_MUL_H, 16'h4000); wr(R_MUL_I, 16'h4000); wr(R_MAC_CMD, 16'h1f41);
        repeat (5) @(posedge clk_sys);
        rd(R_AM_HI, 16'h4000); rd(R_AM_LO, 16'h0000); rd(R_AM_EXT, 16'h0000);
        rd(R_IX, 16'h0001); rd(R_IY, 16'hfffe);
        // Minus one times a half, one step: sign must reach bits 35 to 31
        wr(R_MUL_H, FRAC16_MIN); wr(R_MAC_CMD, 16'h0040);
        repeat (4) @(posedge clk_sys);
        rd(R_AM_EXT, 16'h000f); rd(R_AM_HI, 16'hc000); rd(R_AM_LO, 16'h0000);
        repeat (3) @(posedge clk_sys);
        `CHK(bq.size() + rq.size(), 0)
        $display("mac done");
        complete_run;
    end
endmodule : tb
